// ==== design/tpg_pkg.sv ====
package tpg_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] TPG_CTRL_ADDR   = 8'h00; // Enable, polarities, options.
    localparam logic [7:0] TPG_DIV_ADDR    = 8'h04; // Pixel clock divider.
    localparam logic [7:0] TPG_LINE_ADDR   = 8'h08; // Line sync width and waits.
    localparam logic [7:0] TPG_FRAME_ADDR  = 8'h0c; // Frame sync width and waits.
    localparam logic [7:0] TPG_SIZE_ADDR   = 8'h10; // Pixels per line, display lines per frame.
    localparam logic [7:0] TPG_PIXEL_ADDR  = 8'h14; // Pixel word to drive.
    localparam logic [7:0] TPG_STATUS_ADDR = 8'h18; // Live timing state.

    // Control register bit positions.
    localparam int TPG_CTRL_EN    = 0; // Run the generator.
    localparam int TPG_CTRL_FPOL  = 1; // Frame sync active high when set.
    localparam int TPG_CTRL_LPOL  = 2; // Line sync active high when set.
    localparam int TPG_CTRL_VPOL  = 3; // Data-valid active high when set.
    localparam int TPG_CTRL_CPOL  = 4; // Shift clock inverted when set.
    localparam int TPG_CTRL_DPOL  = 5; // Pixel data inverted when set.
    localparam int TPG_CTRL_GATE  = 6; // Stop shift clock in sync and blanking.
    localparam int TPG_CTRL_ALT   = 7; // Alternate panel variant.
    localparam int TPG_CTRL_WIDTH = 8; // Implemented control bits.

    // Reset values.
    localparam logic [TPG_CTRL_WIDTH-1:0] TPG_CTRL_RST = 8'h00;
    localparam logic [7:0]  TPG_DIV_RST   = 8'h03;
    localparam logic [31:0] TPG_LINE_RST  = 32'h0001_0101;
    localparam logic [31:0] TPG_FRAME_RST = 32'h0001_0101;
    localparam logic [31:0] TPG_SIZE_RST  = 32'h00f0_0140;

    // Fixed idle interval after the line back wait, in shift periods.
    localparam logic [1:0] TPG_IDLE_BLANK = 2'h2;
    localparam logic [1:0] TPG_IDLE_DISP  = 2'h1;
    // Gap from the idle interval to data-valid on every line, in shift periods.
    localparam logic [1:0] TPG_T10_NORM   = 2'h1;
    localparam logic [1:0] TPG_T10_ALT    = 2'h2;
    // Least delay from frame sync end to first data-valid.
    localparam logic [15:0] TPG_T4_MIN    = 16'h0002;

    // Horizontal phases of one line.
    typedef enum logic [2:0] {
        TPG_H_SYNC,
        TPG_H_BACK,
        TPG_H_IDLE,
        TPG_H_T10,
        TPG_H_ACTIVE,
        TPG_H_FRONT
    } tpg_hstate_e;

endpackage : tpg_pkg

// ==== design/tpg_clk_div.sv ====
`timescale 1ns/1ps

// Divides the system clock into a one-cycle shift enable every div+1 cycles.
module tpg_clk_div #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick
);

    logic [WIDTH-1:0] cnt_q; // Cycles since the last tick.
    logic [WIDTH-1:0] cnt_d;
    logic             wrap;  // Count reached the divider value.

    assign wrap  = (cnt_q >= div);
    assign cnt_d = wrap ? '0 : cnt_q + 1'b1;
    assign tick  = run && wrap;

    // Counter is held cleared while idle so the first tick is deterministic.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= run ? cnt_d : '0;
        end
    end

endmodule : tpg_clk_div

// ==== design/tpg_timing_gen.sv ====
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module tpg_timing_gen
    import tpg_pkg::*;
#(
    parameter int PIX_W = 16 // Pixel data bus width.
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             shift_clock,
    output logic             line_sync,
    output logic             frame_sync,
    output logic             data_valid,
    output logic [PIX_W-1:0] pixel_data_bus
);
    import tpg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [TPG_CTRL_WIDTH-1:0] ctrl_q;  // Control bits.
    logic [7:0]                div_q;   // Pixel clock divider.
    logic [31:0]               line_q;  // [7:0] width, [15:8] back, [23:16] front.
    logic [31:0]               frame_q; // [7:0] width, [15:8] back, [23:16] front.
    logic [31:0]               size_q;  // [15:0] pixels per line, [31:16] lines.
    logic [PIX_W-1:0]          pixel_q; // Pixel word driven during data-valid.
    logic                      ack_q;   // Single-cycle acknowledge.
    logic                      err_q;   // Unmapped address answer.
    logic [31:0]               rdat_q;  // Registered read data.

    // Byte-lane merge for a 32-bit register write.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q; // New access.
    wire hit_ctrl = (wb_adr_i == TPG_CTRL_ADDR);
    wire hit_div  = (wb_adr_i == TPG_DIV_ADDR);
    wire hit_line = (wb_adr_i == TPG_LINE_ADDR);
    wire hit_frm  = (wb_adr_i == TPG_FRAME_ADDR);
    wire hit_size = (wb_adr_i == TPG_SIZE_ADDR);
    wire hit_pix  = (wb_adr_i == TPG_PIXEL_ADDR);
    wire hit_stat = (wb_adr_i == TPG_STATUS_ADDR);
    wire hit_any  = hit_ctrl | hit_div | hit_line | hit_frm | hit_size | hit_pix | hit_stat;
    // Writes land on the edge that shows ack to the master, while it still holds the request.
    wire wr       = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;

    logic [31:0] status_w; // Live state, assigned below.
    wire  [31:0] rmux =
        hit_ctrl ? 32'(ctrl_q) : hit_div ? 32'(div_q) : hit_line ? line_q :
        hit_frm ? frame_q : hit_size ? size_q : hit_pix ? 32'(pixel_q) :
        hit_stat ? status_w : 32'h0000_0000;
    wire  [31:0] wnew = merge(rmux, wb_dat_i, wb_sel_i); // Addressed register after the write.

    // Acknowledge one cycle after the request, drop it the cycle after.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req && hit_any;
            err_q  <= req && !hit_any; // Unmapped addresses answer with err.
            rdat_q <= rmux;
        end
    end

    // Register writes; the status word is read-only.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q  <= TPG_CTRL_RST;
            div_q   <= TPG_DIV_RST;
            line_q  <= TPG_LINE_RST;
            frame_q <= TPG_FRAME_RST;
            size_q  <= TPG_SIZE_RST;
            pixel_q <= '0;
        end else if (wr) begin
            if (hit_ctrl) ctrl_q  <= wnew[TPG_CTRL_WIDTH-1:0];
            if (hit_div)  div_q   <= wnew[7:0];
            if (hit_line) line_q  <= wnew;
            if (hit_frm)  frame_q <= wnew;
            if (hit_size) size_q  <= wnew;
            if (hit_pix)  pixel_q <= wnew[PIX_W-1:0];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Shift period enable.

    logic tick; // One pulse per shift-clock period.
    wire  run = ctrl_q[TPG_CTRL_EN];

    tpg_clk_div #(
        .WIDTH (8)
    ) tpg_clk_div_i (
        .clock (clock),
        .reset (reset),
        .run   (run),
        .div   (div_q),
        .tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Field decode.

    wire [15:0] lwidth  = 16'(line_q[7:0]);
    wire [15:0] lback   = 16'(line_q[15:8]);
    wire [15:0] lfront  = 16'(line_q[23:16]);
    wire [15:0] fwidth  = 16'(frame_q[7:0]);
    wire [15:0] fback   = 16'(frame_q[15:8]);
    wire [15:0] ffront  = 16'(frame_q[23:16]);
    wire [15:0] pixels_per_line    = size_q[15:0];
    wire [15:0] ymax    = size_q[31:16];

    ////////////////////////////////////////////////////////////////////////////
    // Line and frame sequencer. Frame lines: sync, back-wait lines,
    // display lines, front-wait lines; each line runs the full horizontal
    // sequence, with the idle phase one period shorter on display lines.

    typedef enum logic [1:0] {
        TPG_V_SYNC,
        TPG_V_BACK,
        TPG_V_DISP,
        TPG_V_FRONT
    } tpg_vstate_e;

    tpg_hstate_e hs_q, hs_d;
    tpg_vstate_e vs_q, vs_d;
    logic [15:0] hcnt_q, hcnt_d; // Periods left in the current phase.
    logic [15:0] vcnt_q, vcnt_d; // Lines left in the current frame phase.
    logic        first_q, first_d; // Display line straight after frame sync (set only with no back wait).

    wire last = (hcnt_q == 16'h0000);
    // Display lines drive data-valid; the last front line is blanking anyway.
    wire disp = (vs_q == TPG_V_DISP);
    wire next_disp = (vs_d == TPG_V_DISP);

    // Advance the vertical phase at the end of a line.
    always_comb begin
        vs_d    = vs_q;
        vcnt_d  = vcnt_q;
        first_d = first_q;
        if (vcnt_q != 16'h0000) begin
            vcnt_d = vcnt_q - 16'h0001;
        end else begin
            unique case (vs_q)
                TPG_V_SYNC: begin
                    // Back-wait lines; zero falls through to display.
                    vs_d    = (fback == 16'h0000) ? TPG_V_DISP : TPG_V_BACK;
                    vcnt_d  = (fback == 16'h0000) ? ymax - 16'h0001 : fback - 16'h0001;
                    first_d = 1'b1;
                end
                TPG_V_BACK: begin
                    vs_d   = TPG_V_DISP;
                    vcnt_d = ymax - 16'h0001;
                end
                TPG_V_DISP: begin
                    vs_d   = (ffront == 16'h0000) ? TPG_V_SYNC : TPG_V_FRONT;
                    vcnt_d = (ffront == 16'h0000) ? fwidth - 16'h0001 : ffront - 16'h0001;
                end
                TPG_V_FRONT: begin
                    vs_d   = TPG_V_SYNC;
                    vcnt_d = fwidth - 16'h0001;
                end
            endcase
        end
    end

    // Horizontal phase machine, stepped once per shift period.
    always_comb begin
        hs_d   = hs_q;
        hcnt_d = hcnt_q - 16'h0001;
        if (last) begin
            unique case (hs_q)
                TPG_H_SYNC: begin
                    hs_d   = TPG_H_BACK;
                    hcnt_d = lback;
                end
                TPG_H_BACK: begin
                    hs_d   = TPG_H_IDLE;
                    // Two periods when blanking, one while displaying.
                    hcnt_d = 16'(disp ? TPG_IDLE_DISP : TPG_IDLE_BLANK) - 16'h0001;
                end
                TPG_H_IDLE: begin
                    // Extra gap before data-valid on every line; longer in the alternate variant.
                    hs_d   = TPG_H_T10;
                    hcnt_d = 16'(ctrl_q[TPG_CTRL_ALT] ? TPG_T10_ALT : TPG_T10_NORM)
                             - 16'h0001;
                end
                TPG_H_T10: begin
                    hs_d   = TPG_H_ACTIVE;
                    hcnt_d = pixels_per_line - 16'h0001;
                end
                TPG_H_ACTIVE: begin
                    hs_d   = TPG_H_FRONT;
                    hcnt_d = lfront;
                end
                TPG_H_FRONT: begin
                    hs_d   = TPG_H_SYNC;
                    hcnt_d = lwidth;
                end
                default: begin
                    hs_d   = TPG_H_SYNC;
                    hcnt_d = lwidth;
                end
            endcase
        end
    end

    wire line_end = last && (hs_q == TPG_H_FRONT);

    // Sequencer state; held at the start of a line while disabled.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hs_q    <= TPG_H_SYNC;
            vs_q    <= TPG_V_SYNC;
            hcnt_q  <= 16'h0000;
            vcnt_q  <= 16'h0000;
            first_q <= 1'b0;
        end else if (!run) begin
            hs_q    <= TPG_H_SYNC;
            vs_q    <= TPG_V_SYNC;
            hcnt_q  <= lwidth;
            vcnt_q  <= fwidth - 16'h0001;
            first_q <= 1'b0;
        end else if (tick) begin
            hs_q   <= hs_d;
            hcnt_q <= hcnt_d;
            if (line_end) begin
                vs_q    <= vs_d;
                vcnt_q  <= vcnt_d;
                first_q <= first_d && next_disp;
            end else if (hs_q == TPG_H_ACTIVE) begin
                first_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Panel outputs.

    wire fs_act = run && (vs_q == TPG_V_SYNC);
    wire ls_act = run && (hs_q == TPG_H_SYNC);
    wire dv_act = run && disp && (hs_q == TPG_H_ACTIVE);
    // Clock gating: stopped during frame sync or data-valid inactive.
    wire sclk_on = !ctrl_q[TPG_CTRL_GATE] || (dv_act && !fs_act);

    logic sclk_q, fs_q, ls_q, dv_q;
    logic [PIX_W-1:0] pd_q;

    // Registered outputs; the shift clock is high for one system clock of each period.
    // With a divider of zero the tick never drops, so the clock then stands high.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b0;
            fs_q   <= 1'b0;
            ls_q   <= 1'b0;
            dv_q   <= 1'b0;
            pd_q   <= '0;
        end else begin
            sclk_q <= run && sclk_on && tick;
            fs_q   <= fs_act ^ !ctrl_q[TPG_CTRL_FPOL];
            ls_q   <= ls_act ^ !ctrl_q[TPG_CTRL_LPOL];
            dv_q   <= dv_act ^ !ctrl_q[TPG_CTRL_VPOL];
            pd_q   <= (dv_act ? pixel_q : '0) ^ {PIX_W{ctrl_q[TPG_CTRL_DPOL]}};
        end
    end

    assign shift_clock    = sclk_q ^ ctrl_q[TPG_CTRL_CPOL];
    assign frame_sync     = fs_q;
    assign line_sync      = ls_q;
    assign data_valid     = dv_q;
    assign pixel_data_bus = pd_q;
    assign status_w = {24'h000000, first_q, dv_act, ls_act, fs_act, 1'b0, hs_q};

endmodule : tpg_timing_gen

// ==== testbench/tpg_timing_checker.sv ====
`timescale 1ns/1ps

// Watches bus answers and panel pulse widths at the generator's ports.
module tpg_timing_checker
    import tpg_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        shift_clock,
    input wire logic        line_sync,
    input wire logic        frame_sync,
    input wire logic        data_valid,
    input wire logic [15:0] pixel_data_bus
);
    logic [7:0]  ctrl_q;    // Last control word written.
    logic [7:0]  div_q;     // Last divider written.
    logic [7:0]  lw_q;      // Last line sync width written.
    logic [15:0] px_q;      // Last pixels per line written.
    logic [15:0] hc_q;      // Clocks of the current line sync pulse.
    logic [15:0] vc_q;      // Clocks of the current data-valid pulse.
    logic [15:0] st_q;      // Clocks since the last register write.
    logic        wr;        // Full-word write accepted this edge.
    logic        line_act;  // Line sync in its active level.
    logic        valid_act; // Data-valid in its active level.
    logic [15:0] lexp;      // Expected line sync length in clocks.
    logic [15:0] vexp;      // Expected data-valid length in clocks.
    logic        mapped;    // Address hits a register.
    assign wr = wb_ack_o && wb_we_i && (wb_sel_i == 4'hf);
    assign line_act = line_sync == ctrl_q[TPG_CTRL_LPOL];
    assign valid_act = data_valid == ctrl_q[TPG_CTRL_VPOL];
    assign lexp = (16'(lw_q) + 16'h1) * (16'(div_q) + 16'h1);
    assign vexp = px_q * (16'(div_q) + 16'h1);
    assign mapped = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    ////////////////////////////////////////////////////////////////////////////
    // Settings are caught on the accepting edge, where the master still holds them.
    // Pulses that began while settings changed are left alone, since they are legal.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= TPG_CTRL_RST;
            div_q  <= TPG_DIV_RST;
            lw_q   <= TPG_LINE_RST[7:0];
            px_q   <= TPG_SIZE_RST[15:0];
            hc_q   <= 16'h0;
            vc_q   <= 16'h0;
            st_q   <= 16'h0;
        end else begin
            if (wr && wb_adr_i == TPG_CTRL_ADDR) ctrl_q <= wb_dat_i[7:0];
            if (wr && wb_adr_i == TPG_DIV_ADDR) div_q <= wb_dat_i[7:0];
            if (wr && wb_adr_i == TPG_LINE_ADDR) lw_q <= wb_dat_i[7:0];
            if (wr && wb_adr_i == TPG_SIZE_ADDR) px_q <= wb_dat_i[15:0];
            hc_q <= line_act ? hc_q + 16'h1 : 16'h0;
            vc_q <= valid_act ? vc_q + 16'h1 : 16'h0;
            st_q <= wr ? 16'h0 : ((st_q == 16'hffff) ? st_q : st_q + 16'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    chk_ack_one_cycle: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
        else $error("answer held longer than one cycle");
    chk_ack_next_edge: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o)
        |=> (wb_ack_o || wb_err_o)) else $error("request not answered in one cycle");
    chk_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !(wb_ack_o || wb_err_o))
        else $error("answer without a request");
    chk_ack_mapped: assert property (wb_ack_o |-> mapped && !wb_err_o)
        else $error("ack on an unmapped address");
    chk_err_unmapped: assert property (wb_err_o |-> !mapped)
        else $error("error on a mapped address");
    chk_line_width: assert property ($fell(line_act) && (hc_q + 16'h2 < st_q) |-> hc_q == lexp)
        else $error("line sync width wrong");
    chk_valid_width: assert property ($fell(valid_act) && (vc_q + 16'h2 < st_q) |-> vc_q == vexp)
        else $error("data-valid width wrong");
    chk_pixel_blank: assert property (!valid_act && st_q > 16'h3
        |-> pixel_data_bus == {16{ctrl_q[TPG_CTRL_DPOL]}}) else $error("pixel bus not blank");
    cover property (wb_err_o);
    cover property ($fell(line_act) && (hc_q + 16'h2 < st_q));
    cover property ($fell(valid_act) && (vc_q + 16'h2 < st_q));
endmodule : tpg_timing_checker

// ==== testbench/tpg_panel_model.sv ====
`timescale 1ns/1ps

// Panel side: measures active-high pulses in system clocks and latches pixels.
module tpg_panel_model (
    input wire logic         clock,
    input wire logic         line_sync,
    input wire logic         data_valid,
    input wire logic [15:0]  pixel_data_bus,
    output logic     [15:0]  sync_w,
    output logic     [15:0]  valid_w,
    output logic     [15:0]  gap,
    output logic     [15:0]  pix,
    output logic     [15:0]  lines
);
    logic [15:0] ls_c = 16'h0; // Clocks of the running line sync.
    logic [15:0] dv_c = 16'h0; // Clocks of the running data-valid.
    logic [15:0] gp_c = 16'h0; // Clocks since data-valid ended.
    logic        seen = 1'b0;  // A data-valid came since the last sync.
    logic        ls_p = 1'b0;  // Line sync one clock ago.
    logic [15:0] ln_c = 16'h0; // Line sync rising edges seen.
    assign lines = ln_c;
    // Only gaps that follow a display line are kept; blanking lines have none.
    always @(posedge clock) begin
        ls_p <= line_sync;
        ls_c <= line_sync ? ls_c + 16'h1 : 16'h0;
        if (!line_sync && ls_c != 16'h0) sync_w <= ls_c;
        dv_c <= data_valid ? dv_c + 16'h1 : 16'h0;
        gp_c <= data_valid ? 16'h0 : gp_c + 16'h1;
        if (data_valid) pix <= pixel_data_bus;
        if (data_valid) seen <= 1'b1;
        if (!data_valid && dv_c != 16'h0) valid_w <= dv_c;
        if (line_sync && !ls_p) begin
            ln_c <= ln_c + 16'h1;
            if (seen) gap <= gp_c;
            seen <= 1'b0;
        end
    end
endmodule : tpg_panel_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps

module tb;
    import tpg_pkg::*;
    logic        clock = 1'b0, reset = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [3:0]  sel = 4'hf;
    logic        ack, err, e, sclk, ls, fs, dv;
    logic [15:0] pd, sync_w, valid_w, gap, pix, lines;
    int          errors = 0, check_count = 0;
    always #5 clock = ~clock;
    tpg_timing_gen tpg_timing_gen_i (.clock(clock), .reset(reset), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err), .shift_clock(sclk), .line_sync(ls),
        .frame_sync(fs), .data_valid(dv), .pixel_data_bus(pd));
    tpg_panel_model tpg_panel_model_i (.clock(clock), .line_sync(ls), .data_valid(dv),
        .pixel_data_bus(pd), .sync_w(sync_w), .valid_w(valid_w), .gap(gap), .pix(pix),
        .lines(lines));
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    // One classic cycle; held until the edge that samples an answer.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; dat <= d;
        do begin @(posedge clock); n++; end while (!(ack || err) && n < 50);
        q = dat_o;
        e = err;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clock);
        if (n >= 50) begin errors++; finish_test(); end
    endtask : wb
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        chk(ls, 1'b1); chk(fs, 1'b1); chk(dv, 1'b1); chk(pd, 16'h0);
        wb(TPG_CTRL_ADDR, 1'b0, 32'h0); chk(q, 32'(TPG_CTRL_RST));
        wb(TPG_DIV_ADDR, 1'b0, 32'h0); chk(q, 32'(TPG_DIV_RST));
        wb(TPG_LINE_ADDR, 1'b0, 32'h0); chk(q, TPG_LINE_RST);
        wb(TPG_FRAME_ADDR, 1'b0, 32'h0); chk(q, TPG_FRAME_RST);
        wb(TPG_SIZE_ADDR, 1'b0, 32'h0); chk(q, TPG_SIZE_RST);
        wb(8'h40, 1'b1, 32'h1); chk(e, 1'b1);
        wb(TPG_CTRL_ADDR, 1'b0, 32'h0); chk(q, 32'h0);
    endtask : test_reset_values
    // Divider 1 gives 2-clock periods; width 2, waits 1, four pixels per line.
    task automatic test_timing();
        int n;
        wb(TPG_DIV_ADDR, 1'b1, 32'h1);
        wb(TPG_LINE_ADDR, 1'b1, 32'h0001_0102);
        wb(TPG_FRAME_ADDR, 1'b1, 32'h0001_0101);
        wb(TPG_SIZE_ADDR, 1'b1, 32'h0002_0004);
        wb(TPG_PIXEL_ADDR, 1'b1, 32'h0000_a5c3);
        wb(TPG_CTRL_ADDR, 1'b1, 32'h0000_002f);
        n = lines + 12;
        for (int i = 0; i < 3000 && lines < n; i++) @(posedge clock);
        if (lines < n) begin errors++; finish_test(); end
        chk(sync_w, 16'd6);
        chk(valid_w, 16'd8);
        chk(gap, 16'd4);
        chk(pix, 16'h5a3c);
    endtask : test_timing
    // With gating on, the shift clock stands still through the frame sync pulse.
    task automatic test_gate();
        logic s;
        wb(TPG_CTRL_ADDR, 1'b1, 32'h0000_006f);
        for (int i = 0; i < 3000 && fs !== 1'b1; i++) @(posedge clock);
        repeat (3) @(posedge clock);
        s = sclk;
        repeat (4) begin
            @(posedge clock);
            chk(sclk, s);
        end
        chk(fs, 1'b1);
    endtask : test_gate
    // Alternate variant: line sync end to data-valid is back 2 + idle 1 + gap 2 periods.
    task automatic test_alt();
        int c;
        logic armed;
        c = 0;
        armed = 1'b0;
        wb(TPG_CTRL_ADDR, 1'b1, 32'h0000_009f);
        for (int i = 0; i < 3000 && !(armed && dv === 1'b1); i++) begin
            @(posedge clock);
            if (ls === 1'b1) begin
                armed = 1'b1;
                c = 0;
            end else if (dv !== 1'b1) begin
                c++;
            end
        end
        chk(c, 32'd10);
        // Stopped with the clock inverted: the shift clock rests high.
        wb(TPG_CTRL_ADDR, 1'b1, 32'h0000_0010);
        repeat (2) @(posedge clock);
        chk(sclk, 1'b1);
        chk(ls, 1'b1);
    endtask : test_alt
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        test_reset_values();
        test_timing();
        test_gate();
        test_alt();
        finish_test();
    end
endmodule : tb

bind tpg_timing_gen tpg_timing_checker tpg_timing_checker_i (.clock(clock), .reset(reset),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .shift_clock(shift_clock), .line_sync(line_sync),
    .frame_sync(frame_sync), .data_valid(data_valid), .pixel_data_bus(pixel_data_bus));
